// ---- apw_chk_properties.sv ----
`timescale 1ns/1ps
// port-level checker for the wake-up timer block
module apw_chk (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    input  wire logic [31:0] avs_readdata_out,
    input  wire logic        avs_waitrequest_out,
    input  wire logic        wave_pin_oe_out,
    input  wire logic        irq_out,
    input  wire logic        wd_reset_out
);
    logic        acc_wr;   // write accepted at this edge
    logic        acc_rd;   // read accepted at this edge
    logic        en_reg;   // shadow of timer enable
    logic        pin_reg;  // shadow of pin access
    logic        csel_reg; // shadow of clock select
    logic [15:0] per_reg;  // shadow of period
    assign acc_wr = avs_write_in && !avs_waitrequest_out;
    assign acc_rd = avs_read_in && !avs_waitrequest_out;
    // shadow control, select only moves while disabled
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            en_reg   <= 1'b0;
            pin_reg  <= 1'b0;
            csel_reg <= 1'b0;
        end else if (acc_wr && avs_address_in == apw_pkg::OFS_CTRL && avs_byteenable_in[0]) begin
            en_reg  <= avs_writedata_in[0];
            pin_reg <= avs_writedata_in[2];
            if (!en_reg) begin
                csel_reg <= avs_writedata_in[1];
            end
        end
    end
    // shadow period, frozen while enabled
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            per_reg <= 16'h0000;
        end else if (acc_wr && avs_address_in == apw_pkg::OFS_PERIOD && !en_reg) begin
            per_reg <= avs_writedata_in[15:0];
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    chk_wait_answer: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("bus request not answered after one wait cycle");
    chk_wait_pulse: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    chk_unmapped_zero: assert property (acc_rd && avs_address_in == 8'h20
        |-> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
    chk_period_lock: assert property (
        acc_rd && avs_address_in == apw_pkg::OFS_PERIOD |-> avs_readdata_out[15:0] == per_reg)
        else $error("period changed while enabled");
    chk_select_lock: assert property (
        acc_rd && avs_address_in == apw_pkg::OFS_CTRL |-> avs_readdata_out[1] == csel_reg)
        else $error("clock select changed while enabled");
    chk_idle_count: assert property (
        acc_rd && avs_address_in == apw_pkg::OFS_COUNT && !en_reg
        |-> avs_readdata_out[15:0] == per_reg) else $error("counter moved while disabled");
    chk_count_bound: assert property (
        acc_rd && avs_address_in == apw_pkg::OFS_COUNT |-> avs_readdata_out[15:0] <= per_reg)
        else $error("counter above period");
    chk_pin_enable: assert property (
        $stable(en_reg) && $stable(pin_reg) && en_reg == $past(en_reg, 2)
        && pin_reg == $past(pin_reg, 2) |-> wave_pin_oe_out == (en_reg && pin_reg))
        else $error("pin enable does not follow control");
    chk_mask_irq: assert property (
        acc_wr && avs_address_in == apw_pkg::OFS_MASK && avs_byteenable_in[0]
        && avs_writedata_in[1:0] == 2'h0 |-> ##2 !irq_out) else $error("masked irq still high");
    chk_bad_service: assert property (
        acc_wr && avs_address_in == apw_pkg::OFS_WDSVC && avs_byteenable_in[0]
        && avs_writedata_in[7:0] != apw_pkg::SVC_FIRST
        && avs_writedata_in[7:0] != apw_pkg::SVC_SECOND |-> ##2 wd_reset_out)
        else $error("bad service value gave no reset");
    chk_reset_pulse: assert property (wd_reset_out |=> !wd_reset_out)
        else $error("watchdog reset longer than one cycle");
endmodule : apw_chk

// ---- apw_pkg.sv ----
package apw_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK   = 8'h0C;
    localparam logic [7:0] OFS_COUNT  = 8'h10;
    localparam logic [7:0] OFS_WDCTL  = 8'h14;
    localparam logic [7:0] OFS_WDSVC  = 8'h18;
    localparam logic [7:0] OFS_WDCNT  = 8'h1C;
    // control field positions
    localparam int CTL_EN_BIT   = 0;
    localparam int CTL_CSEL_BIT = 1;
    localparam int CTL_PIN_BIT  = 2;
    localparam int CTL_TRIM_LSB = 8;
    localparam int TRIM_W       = 6;
    // status and mask bits
    localparam int ST_PER_BIT = 0;
    localparam int ST_WD_BIT  = 1;
    localparam int ST_W       = 2;
    // watchdog control fields
    localparam int WD_SEL_LSB  = 0;
    localparam int WD_WIN_BIT  = 3;
    localparam int WD_LOCK_BIT = 4;
    // reset values
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [5:0]  TRIM_RST   = 6'h00;
    localparam logic [1:0]  MASK_RST   = 2'h0;
    localparam logic [2:0]  WDSEL_RST  = 3'h0;
    // watchdog service values and time-out scale
    localparam logic [7:0]  SVC_FIRST  = 8'h55;
    localparam logic [7:0]  SVC_SECOND = 8'hAA;
    localparam int          WD_EXP_BASE = 7;
    localparam int          WD_CNT_W    = 22;
endpackage : apw_pkg

// ---- apw_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for a pin level
module apw_sync (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_reg; // first stage, read only by second

    // sample the pin twice
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            meta_reg <= 1'b0;
            q_out    <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule : apw_sync

// ---- apw_top.sv ----
`timescale 1ns/1ps
// periodic wake-up timer with watchdog, Avalon-MM slave
module apw_top (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        aclk_pin_in,
    input  wire logic        bus_clk_on_in,
    output logic             wave_pin_out,
    output logic             wave_pin_oe_out,
    output logic             irq_out,
    output logic             wd_reset_out
);
    localparam int CW = apw_pkg::WD_CNT_W;

    // merge write data into a word by byte lane
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  be
    );
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = m;
    endfunction : merge

    // bytes written, zero elsewhere, for clear-by-one
    function automatic logic [31:0] lanes(
        input logic [31:0] nw,
        input logic [3:0]  be
    );
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : 8'h00;
        end
        lanes = m;
    endfunction : lanes

    // ---- register state ----
    logic        en_reg;        // periodic_timer_enable
    logic        csel_reg;      // periodic_clock_select, 1 = autonomous
    logic        pin_reg;       // external_pin_access_enable
    logic [5:0]  trim_reg;      // autonomous_osc_trim
    logic [15:0] period_reg;    // period_value
    logic [1:0]  status_reg;    // sticky event flags
    logic [1:0]  mask_reg;      // bit 0 is periodic_irq_enable
    logic [2:0]  wdsel_reg;     // timeout_select
    logic        wdwin_reg;     // window_mode_enable
    logic        wdlock_reg;    // watchdog control written once

    // ---- timer state ----
    logic [15:0] cnt_reg;       // down counter
    logic        wave_reg;      // waveform level
    logic        aclk_s;        // synchronised autonomous clock
    logic        aclk_d_reg;    // delayed copy for edge
    logic        bus_on_s;      // synchronised bus clock gate

    // ---- bus decode ----
    logic        req;           // read or write pending
    logic        acc;           // access completes this edge
    logic        wr;            // write completes this edge
    logic [31:0] wdat;          // write data alias
    logic [3:0]  be;            // byte enables alias
    logic [31:0] rd_next;       // read data to register

    // ---- events ----
    logic        aclk_tick;     // one cycle per rising autonomous edge
    logic        tick;          // selected timer tick
    logic        expire;        // period elapsed
    logic [1:0]  set_ev;        // events this cycle
    logic [1:0]  clr_ev;        // software clear bits
    logic [CW-1:0] wd_cnt;      // watchdog count
    logic        wd_fire;       // watchdog reset pulse
    logic        svc;           // service write strobe

    // a transfer completes where waitrequest is low;
    // writes land there, reads were taken an edge before
    assign req  = avs_read_in || avs_write_in;
    assign acc  = req && !avs_waitrequest_out;
    assign wr   = acc && avs_write_in;
    assign wdat = avs_writedata_in;
    assign be   = avs_byteenable_in;

    // autonomous clock arrives on a pin: synchronise
    // two flops guard against metastability
    apw_sync u_aclk_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    (aclk_pin_in),
        .q_out   (aclk_s)
    );

    // bus clock gate also comes from outside
    // high means one timer tick per system clock
    apw_sync u_bus_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    (bus_clk_on_in),
        .q_out   (bus_on_s)
    );

    // reset low like the idle pin, so no false edge
    // edge detector on the synchronised level
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            aclk_d_reg <= 1'b0;
        end else begin
            aclk_d_reg <= aclk_s;
        end
    end

    assign aclk_tick = aclk_s && !aclk_d_reg;

    // source select; bus source ticks only while bus clock runs
    // a stopped bus clock gives no ticks: count freezes
    assign tick = csel_reg ? aclk_tick : bus_on_s;

    // expiry when the count has run down on a tick
    // a period spans period_value plus one ticks
    assign expire = en_reg && tick && (cnt_reg == 16'h0000);

    // waitrequest: high idle, low one cycle per request
    // the wait state lets read data come from a flop;
    // a held request is answered every other cycle, high in between
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // read mux; unmapped offsets read zero
    // count views are live and read-only
    always_comb begin
        rd_next = '0;
        case (avs_address_in)
            apw_pkg::OFS_CTRL: begin
                rd_next[apw_pkg::CTL_EN_BIT]   = en_reg;
                rd_next[apw_pkg::CTL_CSEL_BIT] = csel_reg;
                rd_next[apw_pkg::CTL_PIN_BIT]  = pin_reg;
                rd_next[apw_pkg::CTL_TRIM_LSB +: apw_pkg::TRIM_W] = trim_reg;
            end
            apw_pkg::OFS_PERIOD: begin
                rd_next[15:0] = period_reg;
            end
            apw_pkg::OFS_STATUS: begin
                rd_next[apw_pkg::ST_W-1:0] = status_reg;
            end
            apw_pkg::OFS_MASK: begin
                rd_next[apw_pkg::ST_W-1:0] = mask_reg;
            end
            apw_pkg::OFS_COUNT: begin
                rd_next[15:0] = cnt_reg;
            end
            apw_pkg::OFS_WDCTL: begin
                rd_next[apw_pkg::WD_SEL_LSB +: 3] = wdsel_reg;
                rd_next[apw_pkg::WD_WIN_BIT]      = wdwin_reg;
                rd_next[apw_pkg::WD_LOCK_BIT]     = wdlock_reg;
            end
            apw_pkg::OFS_WDCNT: begin
                rd_next[CW-1:0] = wd_cnt;
            end
            default: begin
                rd_next = '0;
            end
        endcase
    end

    // read data captured while waitrequest is high
    // data hold until the next read, so they stand at accept
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            avs_readdata_out <= '0;
        end else if (req && avs_waitrequest_out && avs_read_in) begin
            avs_readdata_out <= rd_next;
        end
    end

    // control register; clock select locked while enabled
    // enable, pin access and trim are always writable
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            en_reg   <= 1'b0;
            csel_reg <= 1'b0;
            pin_reg  <= 1'b0;
            trim_reg <= apw_pkg::TRIM_RST;
        end else if (wr && avs_address_in == apw_pkg::OFS_CTRL) begin
            logic [31:0] c;
            c = merge({18'h0000, trim_reg, 5'h00, pin_reg,
                       csel_reg, en_reg}, wdat, be);
            en_reg   <= c[apw_pkg::CTL_EN_BIT];
            pin_reg  <= c[apw_pkg::CTL_PIN_BIT];
            trim_reg <= c[apw_pkg::CTL_TRIM_LSB +: apw_pkg::TRIM_W];
            // select writes while running are dropped
            if (!en_reg) begin
                csel_reg <= c[apw_pkg::CTL_CSEL_BIT];
            end
        end
    end

    // period register; writes ignored while enabled
    // the lock keeps a running count in step with its period
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            period_reg <= apw_pkg::PERIOD_RST;
        end else if (wr && avs_address_in == apw_pkg::OFS_PERIOD && !en_reg) begin
            period_reg <= 16'(merge({16'h0000, period_reg}, wdat, be));
        end
    end

    // interrupt mask register
    // bit 0 gates the periodic flag, bit 1 the watchdog event
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mask_reg <= apw_pkg::MASK_RST;
        end else if (wr && avs_address_in == apw_pkg::OFS_MASK) begin
            mask_reg <= 2'(merge({30'h0000_0000, mask_reg}, wdat, be));
        end
    end

    // watchdog control: first write locks it
    // the lock guards select and window from stray writes;
    // only a write with byte lane 0 counts as the first
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wdsel_reg  <= apw_pkg::WDSEL_RST;
            wdwin_reg  <= 1'b0;
            wdlock_reg <= 1'b0;
        end else if (wr && avs_address_in == apw_pkg::OFS_WDCTL
                     && !wdlock_reg && be[0]) begin
            wdsel_reg  <= wdat[apw_pkg::WD_SEL_LSB +: 3];
            wdwin_reg  <= wdat[apw_pkg::WD_WIN_BIT];
            wdlock_reg <= 1'b1;
        end
    end

    // status flags; a new event wins over a clear
    // ones written clear flags, zeros leave them alone
    assign set_ev[apw_pkg::ST_PER_BIT] = expire;
    assign set_ev[apw_pkg::ST_WD_BIT]  = wd_fire;
    assign clr_ev = (wr && avs_address_in == apw_pkg::OFS_STATUS)
                    ? 2'(lanes(wdat, be)) : 2'b00;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            status_reg <= 2'b00;
        end else begin
            status_reg <= (status_reg & ~clr_ev) | set_ev;
        end
    end

    // level interrupt from unmasked status
    // one cycle behind the flags
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_reg & mask_reg);
        end
    end

    // down counter: held at period while disabled, no start-up trim
    // reload while stopped makes every start run full length;
    // the tick at zero reloads instead of wrapping
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_reg <= apw_pkg::PERIOD_RST;
        end else if (!en_reg) begin
            cnt_reg <= period_reg;
        end else if (tick) begin
            if (cnt_reg == 16'h0000) begin
                cnt_reg <= period_reg;
            end else begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end

    // waveform toggles on each expiry
    // one toggle per expiry: a square wave of two periods
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wave_reg <= 1'b0;
        end else if (!en_reg) begin
            wave_reg <= 1'b0;
        end else if (expire) begin
            wave_reg <= !wave_reg;
        end
    end

    // pin driven only with timer and pin access enabled
    // enable is high only while the pin is driven
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wave_pin_out    <= 1'b0;
            wave_pin_oe_out <= 1'b0;
        end else begin
            wave_pin_out    <= wave_reg && en_reg && pin_reg;
            wave_pin_oe_out <= en_reg && pin_reg;
        end
    end

    // service strobe on accepted low-byte write
    // service bytes need lane 0; other lanes are ignored
    assign svc = wr && (avs_address_in == apw_pkg::OFS_WDSVC) && be[0];

    // watchdog on the autonomous clock
    // it shares the autonomous tick with the timer
    apw_wdog u_wdog (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .tick_in     (aclk_tick),
        .sel_in      (wdsel_reg),
        .win_in      (wdwin_reg),
        .svc_in      (svc),
        .svc_data_in (wdat[7:0]),
        .cnt_out     (wd_cnt),
        .reset_out   (wd_fire)
    );

    // reset request delayed one cycle into a registered pulse
    // one registered cycle per watchdog request
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wd_reset_out <= 1'b0;
        end else begin
            wd_reset_out <= wd_fire;
        end
    end
endmodule : apw_top

// ---- apw_wdog.sv ----
`timescale 1ns/1ps
// watchdog counter with service check and window
module apw_wdog (
    input  wire logic                          mclk_in,
    input  wire logic                          rst_in,
    input  wire logic                          tick_in,
    input  wire logic [2:0]                    sel_in,
    input  wire logic                          win_in,
    input  wire logic                          svc_in,
    input  wire logic [7:0]                    svc_data_in,
    output logic      [apw_pkg::WD_CNT_W-1:0]  cnt_out,
    output logic                               reset_out
);
    localparam int CW = apw_pkg::WD_CNT_W;

    // time-out length for a select code
    function automatic logic [CW-1:0] limit_of(input logic [2:0] s);
        limit_of = CW'(1) << (apw_pkg::WD_EXP_BASE + 2 * int'(s));
    endfunction : limit_of

    logic [CW-1:0] lim;        // current time-out
    logic          on;         // watchdog running
    logic          armed_reg;  // first value seen
    logic          bad;        // illegal value
    logic          early;      // write before window
    logic          expire;     // counted out
    logic          fire;       // reset request

    assign lim    = limit_of(sel_in);
    assign on     = (sel_in != 3'h0);
    assign bad    = svc_in && (svc_data_in != apw_pkg::SVC_FIRST)
                    && (svc_data_in != apw_pkg::SVC_SECOND);
    assign early  = svc_in && win_in && (cnt_out < (lim - (lim >> 2)));
    assign expire = tick_in && (cnt_out == lim - CW'(1));
    assign fire   = on && (bad || early || expire);

    // counter, restart and sequence tracking
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_out   <= '0;
            armed_reg <= 1'b0;
            reset_out <= 1'b0;
        end else begin
            reset_out <= fire;
            if (!on || fire) begin
                cnt_out   <= '0;
                armed_reg <= 1'b0;
            end else if (svc_in) begin
                armed_reg <= (svc_data_in == apw_pkg::SVC_FIRST);
                if (armed_reg && svc_data_in == apw_pkg::SVC_SECOND) begin
                    cnt_out <= '0;
                end else if (tick_in) begin
                    cnt_out <= cnt_out + CW'(1);
                end
            end else if (tick_in) begin
                cnt_out <= cnt_out + CW'(1);
            end
        end
    end
endmodule : apw_wdog

// ---- tb_top.sv ----
`timescale 1ns/1ps
// register-level bench for the wake-up timer block
module tb_top;
    logic        mclk_in = 1'b0;   // 10 MHz system clock
    logic        rst_in  = 1'b1;   // synchronous reset
    logic [7:0]  a_adr   = 8'h00;  // bus address
    logic        a_rd    = 1'b0;   // bus read
    logic        a_wr    = 1'b0;   // bus write
    logic [31:0] a_wd    = 32'h0000_0000;
    logic [3:0]  a_be    = 4'hF;   // all lanes
    logic        aclk    = 1'b0;   // autonomous clock pin
    logic        bon     = 1'b1;   // bus clock running
    logic [31:0] a_rdat;
    logic        a_wait;
    logic        wave;
    logic        oe;
    logic        irq;
    logic        wdr;
    logic [31:0] got;              // data of last access
    logic [31:0] c1;               // held counter value
    logic        v;                // held wave level
    int          n_mismatch = 0;
    int          checked    = 0;
    logic [7:0]  ra [6] = '{apw_pkg::OFS_CTRL, apw_pkg::OFS_PERIOD, apw_pkg::OFS_STATUS,
                            apw_pkg::OFS_MASK, apw_pkg::OFS_WDCTL, 8'h20};
    always #50 mclk_in = ~mclk_in;
    apw_top dut_u (
        .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(a_adr), .avs_read_in(a_rd),
        .avs_write_in(a_wr), .avs_writedata_in(a_wd), .avs_byteenable_in(a_be),
        .avs_readdata_out(a_rdat), .avs_waitrequest_out(a_wait), .aclk_pin_in(aclk),
        .bus_clk_on_in(bon), .wave_pin_out(wave), .wave_pin_oe_out(oe), .irq_out(irq),
        .wd_reset_out(wdr)
    );
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk_in);
        a_adr <= a;
        a_wd  <= d;
        a_wr  <= w;
        a_rd  <= !w;
        do begin
            @(posedge mclk_in);
            k++;
        end while (a_wait !== 1'b0 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            $display("[ERR] %0t bus access never answered", $time);
        end
        got = a_rdat;
        a_wr <= 1'b0;
        a_rd <= 1'b0;
    endtask : bus
    // register value compare
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t register exp %h got %h", $time, e, g);
        end
    endtask : cmp
    // pin level compare
    task automatic pinchk(input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t pin exp %b got %b", $time, e, g);
        end
    endtask : pinchk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wreg
    // read and compare the masked bits
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0000_0000);
        cmp(e & m, got & m);
    endtask : rreg
    // pulses on the autonomous clock pin, four cycles each
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            aclk <= 1'b1;
            repeat (2) @(posedge mclk_in);
            aclk <= 1'b0;
            @(posedge mclk_in);
        end
        repeat (5) @(posedge mclk_in);
    endtask : tick
    // looks for a watchdog reset pulse after a service write
    task automatic wdchk(input logic e);
        logic s;
        s = 1'b0;
        repeat (4) begin
            @(posedge mclk_in);
            s = s | (wdr === 1'b1);
        end
        pinchk(e, s);
    endtask : wdchk
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        wreg(8'h20, 32'hFFFF_FFFF);
        foreach (ra[i]) rreg(ra[i], 32'h0000_0000, 32'hFFFF_FFFF);
        wreg(apw_pkg::OFS_PERIOD, 32'h0000_0005);
        rreg(apw_pkg::OFS_PERIOD, 32'h0000_0005, 32'h0000_FFFF);
        repeat (10) @(posedge mclk_in);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
        rreg(apw_pkg::OFS_COUNT, 32'h0000_0005, 32'h0000_FFFF);
        wreg(apw_pkg::OFS_CTRL, 32'h0000_0001);
        wreg(apw_pkg::OFS_PERIOD, 32'h0000_0009);
        rreg(apw_pkg::OFS_PERIOD, 32'h0000_0005, 32'h0000_FFFF);
        wreg(apw_pkg::OFS_CTRL, 32'h0000_0003);
        rreg(apw_pkg::OFS_CTRL, 32'h0000_0001, 32'h0000_0003);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        wreg(apw_pkg::OFS_STATUS, 32'h0000_0001);
        repeat (20) @(posedge mclk_in);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        wreg(apw_pkg::OFS_MASK, 32'h0000_0001);
        repeat (3) @(posedge mclk_in);
        pinchk(1'b1, irq);
        wreg(apw_pkg::OFS_MASK, 32'h0000_0000);
        repeat (3) @(posedge mclk_in);
        pinchk(1'b0, irq);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        wreg(apw_pkg::OFS_CTRL, 32'h0000_0005);
        repeat (3) @(posedge mclk_in);
        pinchk(1'b1, oe);
        v = wave;
        repeat (6) @(posedge mclk_in);
        pinchk(~v, wave);
        bon <= 1'b0;
        repeat (5) @(posedge mclk_in);
        bus(1'b0, apw_pkg::OFS_COUNT, 32'h0000_0000);
        c1 = got;
        repeat (10) @(posedge mclk_in);
        rreg(apw_pkg::OFS_COUNT, c1, 32'h0000_FFFF);
        bon <= 1'b1;
        wreg(apw_pkg::OFS_CTRL, 32'h0000_0000);
        wreg(apw_pkg::OFS_STATUS, 32'h0000_0000);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        wreg(apw_pkg::OFS_STATUS, 32'h0000_0001);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
        pinchk(1'b0, oe);
        wreg(apw_pkg::OFS_PERIOD, 32'h0000_0020);
        wreg(apw_pkg::OFS_CTRL, 32'h0000_0003);
        rreg(apw_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_0003);
        repeat (10) @(posedge mclk_in);
        rreg(apw_pkg::OFS_COUNT, 32'h0000_0020, 32'h0000_FFFF);
        tick(3);
        rreg(apw_pkg::OFS_COUNT, 32'h0000_001D, 32'h0000_FFFF);
        wreg(apw_pkg::OFS_CTRL, 32'h0000_2A02);
        rreg(apw_pkg::OFS_CTRL, 32'h0000_2A02, 32'h0000_3F07);
        wreg(apw_pkg::OFS_WDCTL, 32'h0000_0009);
        wreg(apw_pkg::OFS_WDCTL, 32'h0000_0001);
        rreg(apw_pkg::OFS_WDCTL, 32'h0000_0019, 32'h0000_001F);
        wreg(apw_pkg::OFS_WDSVC, 32'h0000_0055);
        wdchk(1'b1);
        rreg(apw_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        tick(400);
        wreg(apw_pkg::OFS_WDSVC, 32'h0000_0055);
        wdchk(1'b0);
        wreg(apw_pkg::OFS_WDSVC, 32'h0000_00AA);
        wdchk(1'b0);
        rreg(apw_pkg::OFS_WDCNT, 32'h0000_0000, 32'h003F_FFFF);
        tick(390);
        wreg(apw_pkg::OFS_WDSVC, 32'h0000_0012);
        wdchk(1'b1);
        summarize();
    end
    // cuts a hang short
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        $display("[ERR] %0t run did not finish in time", $time);
        summarize();
    end
endmodule : tb_top
bind apw_top apw_chk chk_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .wave_pin_oe_out(wave_pin_oe_out), .irq_out(irq_out), .wd_reset_out(wd_reset_out)
);
